// ===== splw_cfg.svh
`ifndef SPLW_CFG_SVH
`define SPLW_CFG_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define SPLW_IDX_PORT_EN     16'h3C48
`define SPLW_IDX_GLOBAL_EN   16'h4141
`define SPLW_IDX_TMO_SEL     16'h4171
`define SPLW_IDX_OFF_DUR     16'h4176
`define SPLW_IDX_STATUS      16'h4180

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define SPLW_PORT5_EN_BIT    5
`define SPLW_PORT6_EN_BIT    6
`define SPLW_GLOBAL_EN_BIT   0
`define SPLW_TMO_SEL_RST     3'h5
`define SPLW_OFF_DUR_RST     8'h05

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SPLW_CLK_PERIOD_NS   10
`define SPLW_MS_NS           1000000
`define SPLW_CYC_PER_MS      (`SPLW_MS_NS / `SPLW_CLK_PERIOD_NS)
`define SPLW_TMO_100_MS      100
`define SPLW_TMO_250_MS      250
`define SPLW_TMO_500_MS      500
`define SPLW_TMO_750_MS      750
`define SPLW_TMO_1000_MS     1000
`define SPLW_TMO_2000_MS     2000
`define SPLW_OFF_MIN_MS      350
`define SPLW_OFF_STEP_MS     10

`endif

// ===== splw_link_partner.sv
`default_nettype none
module splw_link_partner (
  // Clock
  input  wire logic                 core_clk_i,
  // Power in and bench command
  input  wire logic                 power_i,
  input  wire logic                 stuck_i,
  // Link state out
  output var  splw_pkg::splw_link_t link_state_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import splw_pkg::*;
  // Unpowered: disabled; stuck: held in detect; healthy: moves every cycle
  always @(posedge core_clk_i) begin
    if (!power_i) link_state_o <= 4'h4;
    else if (stuck_i) link_state_o <= 4'h5;
    else link_state_o <= link_state_o + 4'h1;
  end
endmodule : splw_link_partner
`default_nettype wire

// ===== splw_pkg.sv
`default_nettype none

package splw_pkg;

  typedef logic [3:0]  splw_link_t;
  typedef logic [11:0] splw_ms_t;

  typedef struct packed {
    logic [19:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } splw_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } splw_apb_rsp_s;

  typedef struct packed {
    logic [2:0]            tmo_sel;
    logic [7:0]            off_dur;
    logic [1:0]            port_en;
    logic                  global_en;
    logic [16:0]           presc;
    logic [1:0][11:0]      stuck_cnt;
    logic [1:0][3:0]       prev_state;
    logic [1:0][11:0]      off_cnt;
    logic [1:0]            pwr;
    splw_apb_rsp_s         rsp;
  } splw_state_s;

endpackage : splw_pkg

`default_nettype wire

// ===== splw_watchdog.sv
// Our own choice: register access over APB.
`include "splw_cfg.svh"
`default_nettype none

module splw_watchdog #(
  parameter int CYC_PER_MS = `SPLW_CYC_PER_MS
) (
  // Clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     arst_n_i,
  // APB slave
  input  wire splw_pkg::splw_apb_req_s  apb_req_i,
  output var  splw_pkg::splw_apb_rsp_s  apb_rsp_o,
  // Link state of ports 5 and 6
  input  wire splw_pkg::splw_link_t     link_state_i [2],
  // Split SuperSpeed power, index 0 is port 5
  output var  logic [1:0]               superspeed_half_power_out_o
);
  import splw_pkg::*;

  // --------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic splw_ms_t tmo_ms(input logic [2:0] sel);
    unique case (sel)
      3'h1:    tmo_ms = 12'(`SPLW_TMO_100_MS);
      3'h2:    tmo_ms = 12'(`SPLW_TMO_250_MS);
      3'h3:    tmo_ms = 12'(`SPLW_TMO_500_MS);
      3'h4:    tmo_ms = 12'(`SPLW_TMO_750_MS);
      3'h5:    tmo_ms = 12'(`SPLW_TMO_1000_MS);
      3'h6:    tmo_ms = 12'(`SPLW_TMO_2000_MS);
      default: tmo_ms = 12'h000;
    endcase
  endfunction : tmo_ms

  function automatic splw_ms_t off_ms(input logic [7:0] dur);
    off_ms = 12'(`SPLW_OFF_MIN_MS) + 12'(dur) * 12'(`SPLW_OFF_STEP_MS);
  endfunction : off_ms

  function automatic logic is_stuck(input splw_link_t st);
    is_stuck = (st >= 4'h4) && (st <= 4'h9);
  endfunction : is_stuck

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  splw_state_s state_reg;
  splw_state_s state_next;
  logic        ms_tick;
  logic        port_on;
  logic        access;
  logic [15:0] idx;

  always_comb begin
    state_next             = state_reg;
    state_next.rsp.pready  = 1'b0;
    state_next.rsp.pslverr = 1'b0;
    ms_tick                = (state_reg.presc == 17'(CYC_PER_MS - 1));
    state_next.presc       = ms_tick ? 17'h0_0000 : state_reg.presc + 17'h0_0001;
    access                 = apb_req_i.psel && apb_req_i.penable;
    idx                    = apb_req_i.paddr[17:2];
    port_on                = 1'b0;

    // Answer one cycle into the access phase
    if (access && !state_reg.rsp.pready) begin
      state_next.rsp.pready = 1'b1;
      state_next.rsp.prdata = 32'h0000_0000;
      if (apb_req_i.paddr[1:0] != 2'b00 || apb_req_i.paddr[19:18] != 2'b00) begin
        state_next.rsp.pslverr = 1'b1;
      end else begin
        unique case (idx)
          `SPLW_IDX_PORT_EN: begin
            state_next.rsp.prdata[`SPLW_PORT5_EN_BIT] = state_reg.port_en[0];
            state_next.rsp.prdata[`SPLW_PORT6_EN_BIT] = state_reg.port_en[1];
          end
          `SPLW_IDX_GLOBAL_EN:
            state_next.rsp.prdata[`SPLW_GLOBAL_EN_BIT] = state_reg.global_en;
          `SPLW_IDX_TMO_SEL: state_next.rsp.prdata[2:0] = state_reg.tmo_sel;
          `SPLW_IDX_OFF_DUR: state_next.rsp.prdata[7:0] = state_reg.off_dur;
          `SPLW_IDX_STATUS: begin
            state_next.rsp.prdata[1:0]  = state_reg.pwr;
            state_next.rsp.prdata[7:4]  = link_state_i[0];
            state_next.rsp.prdata[11:8] = link_state_i[1];
          end
          default: state_next.rsp.pslverr = 1'b1;
        endcase
      end
    end

    // Write lands on the completing edge
    if (access && state_reg.rsp.pready && apb_req_i.pwrite && apb_req_i.pstrb[0]
        && !state_reg.rsp.pslverr) begin
      unique case (idx)
        `SPLW_IDX_PORT_EN: begin
          state_next.port_en[0] = apb_req_i.pwdata[`SPLW_PORT5_EN_BIT];
          state_next.port_en[1] = apb_req_i.pwdata[`SPLW_PORT6_EN_BIT];
        end
        `SPLW_IDX_GLOBAL_EN: state_next.global_en = apb_req_i.pwdata[`SPLW_GLOBAL_EN_BIT];
        `SPLW_IDX_TMO_SEL:   state_next.tmo_sel   = apb_req_i.pwdata[2:0];
        `SPLW_IDX_OFF_DUR:   state_next.off_dur   = apb_req_i.pwdata[7:0];
        default: ;
      endcase
    end

    // Per-port link watch and power pulse
    for (int i = 0; i < 2; i++) begin
      port_on = state_reg.port_en[i] && state_reg.global_en;
      if (!state_reg.pwr[i]) begin
        if (ms_tick) begin
          if (state_reg.off_cnt[i] + 12'h001 >= off_ms(state_reg.off_dur)) begin
            state_next.pwr[i]     = 1'b1;
            state_next.off_cnt[i] = 12'h000;
          end else begin
            state_next.off_cnt[i] = state_reg.off_cnt[i] + 12'h001;
          end
        end
      end else if (!port_on || tmo_ms(state_reg.tmo_sel) == 12'h000
                   || !is_stuck(link_state_i[i])
                   || link_state_i[i] != state_reg.prev_state[i]) begin
        state_next.stuck_cnt[i] = 12'h000;
      end else if (ms_tick) begin
        if (state_reg.stuck_cnt[i] + 12'h001 >= tmo_ms(state_reg.tmo_sel)) begin
          state_next.pwr[i]       = 1'b0;
          state_next.stuck_cnt[i] = 12'h000;
        end else begin
          state_next.stuck_cnt[i] = state_reg.stuck_cnt[i] + 12'h001;
        end
      end
      state_next.prev_state[i] = link_state_i[i];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg         <= '0;
      state_reg.tmo_sel <= `SPLW_TMO_SEL_RST;
      state_reg.off_dur <= `SPLW_OFF_DUR_RST;
      state_reg.pwr     <= 2'b11;
    end else begin
      state_reg <= state_next;
    end
  end

  assign apb_rsp_o                   = state_reg.rsp;
  assign superspeed_half_power_out_o = state_reg.pwr;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_reg);

  pulse_needs_enable_a: assert property ($fell(state_reg.pwr[0]) |->
    $past(state_reg.port_en[0] && state_reg.global_en))
    else $error("Port 5 pulse without enable");

  pulse_from_stuck_a: assert property ($fell(state_reg.pwr[1]) |->
    $past(is_stuck(link_state_i[1])))
    else $error("Port 6 pulse outside stuck states");

  timeout_full_a: assert property ($fell(state_reg.pwr[0]) |->
    $past(state_reg.stuck_cnt[0]) + 12'h001 >= tmo_ms($past(state_reg.tmo_sel)))
    else $error("Pulse before timeout elapsed");

  timeout_off_a: assert property ((state_reg.tmo_sel == 3'h0) |=>
    !$fell(state_reg.pwr[0]) && !$fell(state_reg.pwr[1]))
    else $error("Pulse while timeout disabled");

  timer_restart_a: assert property ($fell(state_reg.pwr[0]) |->
    state_reg.stuck_cnt[0] == 12'h000)
    else $error("Stuck timer not restarted");

  off_length_a: assert property ($rose(state_reg.pwr[0]) |->
    $past(state_reg.off_cnt[0]) + 12'h001 >= off_ms($past(state_reg.off_dur)))
    else $error("Power off pulse too short");

  off_timer_clear_a: assert property ($rose(state_reg.pwr[1]) |->
    state_reg.off_cnt[1] == 12'h000)
    else $error("Off timer not cleared");

  link_moving_a: assert property ((link_state_i[0] != state_reg.prev_state[0]
    && state_reg.pwr[0]) |=> state_reg.stuck_cnt[0] == 12'h000)
    else $error("Moving link counted as stuck");

  pulse_low_hold_a: assert property ($fell(state_reg.pwr[0]) |=>
    !state_reg.pwr[0] [*2])
    else $error("Power pulse released early");

  apb_one_wait_a: assert property ((apb_req_i.psel && apb_req_i.penable
    && !state_reg.rsp.pready) |=> state_reg.rsp.pready)
    else $error("APB answer late");

  pulse_start_c: cover property ($fell(state_reg.pwr[0]));
  pulse_end_c:   cover property ($rose(state_reg.pwr[1]));
  apb_write_c:   cover property (apb_req_i.psel && apb_req_i.penable
    && apb_req_i.pwrite && state_reg.rsp.pready);
  repeat_c:      cover property ($rose(state_reg.pwr[0]) ##[1:20] (state_reg.stuck_cnt[0] != 12'h000));

endmodule : splw_watchdog

`default_nettype wire

// ===== test_splw_watchdog.sv
`include "splw_cfg.svh"
`default_nettype none
module test_splw_watchdog;
  timeunit 1ns;
  timeprecision 1ps;
  import splw_pkg::*;
  localparam int CYC = 10;
  logic          core_clk_i = 1'b0;
  logic          arst_n_i = 1'b0;
  splw_apb_req_s req = '0;
  splw_apb_rsp_s rsp;
  splw_link_t    ls [2];
  logic [1:0]    pwr;
  logic          stuck = 1'b1;
  logic          watch6 = 1'b0;
  logic          p6_fell = 1'b0;
  logic [31:0]   rd;
  logic          err;
  int            bad_count = 0;
  int            checks_done = 0;
  int            n, t, d;

  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (watch6 && pwr[1] !== 1'b1) p6_fell <= 1'b1;

  splw_watchdog #(.CYC_PER_MS(CYC)) splw_watchdog_i (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .apb_req_i(req), .apb_rsp_o(rsp),
    .link_state_i(ls), .superspeed_half_power_out_o(pwr));
  for (genvar g = 0; g < 2; g++) begin : g_dev
    splw_link_partner splw_link_partner_i (
      .core_clk_i(core_clk_i), .power_i(pwr[g]), .stuck_i(stuck), .link_state_o(ls[g]));
  end

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int k;
    @(posedge core_clk_i);
    req <= '{paddr: 20'({idx, 2'b00}), psel: 1'b1, penable: 1'b0, pwrite: wr,
             pwdata: wd, pstrb: 4'hF};
    @(posedge core_clk_i);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (rsp.pready !== 1'b1 && k < 16);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (k >= 16) begin
      chk("pready", 32'(rsp.pready), 32'h0000_0001);
      finish_test();
    end
  endtask : apb

  task automatic wait_pwr(input int p, input logic lvl, input int lim, input bit must);
    n = 0;
    while (pwr[p] !== lvl && n < lim) begin
      @(posedge core_clk_i);
      n++;
    end
    if (must && pwr[p] !== lvl) begin
      chk("power level", 32'(pwr[p]), 32'(lvl));
      finish_test();
    end
  endtask : wait_pwr

  task automatic in_range(input string name, input int lo, input int hi);
    chk(name, 32'(n >= lo && n <= hi), 32'h0000_0001);
  endtask : in_range

  function automatic int tmo_ms(input int c);
    case (c)
      1: return 100;
      2: return 250;
      3: return 500;
      4: return 750;
      5: return 1000;
      default: return 2000;
    endcase
  endfunction : tmo_ms

  initial begin
    repeat (5) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    apb(0, `SPLW_IDX_TMO_SEL, 0); chk("timeout reset", rd, 32'h0000_0005);
    apb(0, `SPLW_IDX_OFF_DUR, 0); chk("off reset", rd, 32'h0000_0005);
    apb(0, `SPLW_IDX_PORT_EN, 0); chk("port en reset", rd, 32'h0000_0000);
    apb(0, `SPLW_IDX_GLOBAL_EN, 0); chk("global reset", rd, 32'h0000_0000);
    apb(1, `SPLW_IDX_TMO_SEL, 32'h0000_00FF);
    apb(0, `SPLW_IDX_TMO_SEL, 0); chk("timeout field", rd, 32'h0000_0007);
    apb(0, 16'h0001, 0); chk("unmapped error", 32'(err), 32'h0000_0001);
    apb(1, `SPLW_IDX_PORT_EN, 32'h0000_0060);
    apb(1, `SPLW_IDX_GLOBAL_EN, 32'h0000_0001);
    // Codes that must never pulse
    for (int c = 0; c < 8; c += 7) begin
      apb(1, `SPLW_IDX_TMO_SEL, 32'(c));
      wait_pwr(0, 0, 1500, 0); chk("no pulse", 32'(pwr), 32'h0000_0003);
    end
    stuck <= 1'b0;
    apb(1, `SPLW_IDX_TMO_SEL, 32'h0000_0001);
    wait_pwr(0, 0, 1500, 0); chk("moving link", 32'(pwr), 32'h0000_0003);
    apb(1, `SPLW_IDX_GLOBAL_EN, 0);
    stuck <= 1'b1;
    wait_pwr(0, 0, 1500, 0); chk("global off", 32'(pwr), 32'h0000_0003);
    apb(1, `SPLW_IDX_GLOBAL_EN, 32'h0000_0001);
    wait_pwr(0, 0, 1200, 1); chk("shared timeout", 32'(pwr), 32'h0000_0000);
    apb(0, `SPLW_IDX_STATUS, 0); chk("status in pulse", rd, 32'h0000_0440);
    wait_pwr(0, 1, 4200, 1);
    apb(1, `SPLW_IDX_TMO_SEL, 0);
    apb(1, `SPLW_IDX_PORT_EN, 32'h0000_0020);
    watch6 <= 1'b1;
    for (int c = 1; c < 7; c++) begin
      apb(1, `SPLW_IDX_OFF_DUR, 32'(c - 1));
      apb(1, `SPLW_IDX_TMO_SEL, 32'(c));
      t = tmo_ms(c) * CYC;
      d = (350 + 10 * (c - 1)) * CYC;
      for (int r = 0; r < ((c == 1) ? 2 : 1); r++) begin
        wait_pwr(0, 0, t + CYC + 8, 1); in_range("timeout", t - CYC, t + CYC + 8);
        wait_pwr(0, 1, d + CYC + 2, 1); in_range("off time", d - CYC, d + CYC + 2);
      end
      apb(1, `SPLW_IDX_TMO_SEL, 0);
    end
    chk("port 6 quiet", 32'(p6_fell), 32'h0000_0000);
    finish_test();
  end
endmodule : test_splw_watchdog
`default_nettype wire
